// [hw/fpo_defines.vh]
// Constants for the flash protection override command block.
`ifndef FPO_DEFINES_VH
`define FPO_DEFINES_VH

// ****************************************************************
// Register map (word addresses on the plain register port).
// ****************************************************************
`define FPO_ADDR_W 4
`define FPO_DATA_W 16
`define FPO_ADDR_CMD_STATUS 4'h0
`define FPO_ADDR_CMD_CONFIG 4'h1
`define FPO_ADDR_ERR_CONFIG 4'h2
`define FPO_ADDR_ERR_STATUS 4'h3
`define FPO_ADDR_PROT_STATUS 4'h4
`define FPO_ADDR_PFLASH_PROT 4'h5
`define FPO_ADDR_EEPROM_PROT 4'h6
`define FPO_ADDR_PARAM 4'h7

// ****************************************************************
// Field positions.
// ****************************************************************
`define FPO_CC_BIT 7
`define FPO_ACC_BIT 5
`define FPO_PV_BIT 4
`define FPO_VE_HI_BIT 1
`define FPO_VE_LO_BIT 0
`define FPO_CIE_BIT 7
`define FPO_IDX_HI 2
`define FPO_IDX_LO 0
`define FPO_SFIE_BIT 0
`define FPO_SFF_BIT 0
`define FPO_OVR_BIT 0
`define FPO_CODE_HI 15
`define FPO_CODE_LO 8
`define FPO_SEL_PF 0
`define FPO_SEL_EE 1
`define FPO_PROT_HI 7
`define FPO_PROT_LO 0

// ****************************************************************
// Codes and values.
// ****************************************************************
`define FPO_CMD_OVERRIDE 8'h13
`define FPO_KEY_ERASED 16'hffff
`define FPO_SEL_NONE 2'h0
`define FPO_IDX_W1 3'h1
`define FPO_IDX_W2 3'h2
`define FPO_IDX_W3 3'h3
`define FPO_PROT_RESET 8'h00
`define FPO_DATA_ZERO 16'h0000

`endif

// [hw/fpo_prot_reg.v]
// One protection register with its single-entry save slot.
`timescale 1ns/100ps
`include "fpo_defines.vh"
module fpo_prot_reg #(
   parameter [7:0] RESET_VALUE = `FPO_PROT_RESET
) (
   // Clock and reset.
   input wire mclk_i,
   input wire arst_n_i,
   // Direct software write.
   input wire sw_we_i,
   input wire [7:0] sw_data_i,
   // Command side controls.
   input wire save_i,
   input wire load_i,
   input wire [7:0] load_data_i,
   input wire restore_i,
   // Current protection value.
   output reg [7:0] value_o
);

   reg [7:0] saved; // Value held before the last override.

   // ****************************************************************
   // Value and save slot.
   // ****************************************************************
   // Command actions take priority over a software write in the same
   // cycle, so an override is never half undone by a racing store.
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         value_o <= RESET_VALUE;
         saved <= RESET_VALUE;
      end else begin
         if (save_i) begin
            saved <= value_o;
         end
         if (restore_i) begin
            // Reload the slot; direct writes since then are dropped.
            value_o <= saved;
         end else if (load_i) begin
            value_o <= load_data_i;
         end else if (sw_we_i) begin
            value_o <= sw_data_i;
         end
      end
   end

endmodule

// [hw/fpo_irq.v]
// Interrupt request formed from one flag and its enable.
`timescale 1ns/100ps
module fpo_irq (
   // Clock and reset.
   input wire mclk_i,
   input wire arst_n_i,
   // Flag and local enable.
   input wire flag_i,
   input wire enable_i,
   // Registered request.
   output reg irq_o
);

   // ****************************************************************
   // Request register.
   // ****************************************************************
   // Registered so the request leaves the block from a flip-flop; it
   // follows the flag and enable one cycle late.
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= flag_i & enable_i;
      end
   end

endmodule

// [hw/fpo_top.v]
// Flash protection override command logic with its register port.
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/100ps
`include "fpo_defines.vh"
module fpo_top (
   // Clock and reset.
   input wire mclk_i,
   input wire arst_n_i,
   // Register port.
   input wire [`FPO_ADDR_W-1:0] addr_i,
   input wire [`FPO_DATA_W-1:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [`FPO_DATA_W-1:0] rdata_o,
   // Flash array side, same clock domain.
   input wire [`FPO_DATA_W-1:0] stored_key_i,
   input wire cmd_allowed_i,
   input wire single_fault_i,
   // Protection outputs.
   output wire [7:0] pflash_protection_o,
   output wire [7:0] eeprom_protection_o,
   // Status and interrupt requests.
   output reg command_complete_o,
   output reg override_active_o,
   output wire cmd_irq_o,
   output wire err_irq_o
);

   // ****************************************************************
   // State encoding.
   // ****************************************************************
   localparam [1:0] ST_IDLE = 2'h0; // Waiting for a launch.
   localparam [1:0] ST_EXEC = 2'h1; // Evaluating the command.
   localparam [1:0] ST_DONE = 2'h2; // Completing, flag set next.

   // ****************************************************************
   // Declarations.
   // ****************************************************************
   reg [1:0] state; // Command sequencer state.
   reg [1:0] next_state; // Next sequencer state.
   reg access_error; // Sticky launch error flag.
   reg command_complete_irq_en; // Command interrupt enable.
   reg single_fault_irq_en; // Single-bit fault interrupt enable.
   reg single_fault_flag; // Sticky single-bit fault flag.
   reg [2:0] param_index; // Selects the parameter word window.
   reg [`FPO_DATA_W-1:0] param_word [0:3]; // Command parameters.
   reg [2:0] launch_index; // Index captured at launch.
   reg cmd_error; // Error verdict from the checks.
   reg do_override; // Apply new values this cycle.
   reg do_restore; // Restore saved values this cycle.
   wire [7:0] protection_violation; // Held flags kept at zero.
   wire [`FPO_DATA_W-1:0] param_word_0; // Code and selection.
   wire [`FPO_DATA_W-1:0] param_word_1; // Comparison key.
   wire [`FPO_DATA_W-1:0] param_word_2; // New pflash value.
   wire [`FPO_DATA_W-1:0] param_word_3; // New eeprom value.
   wire [1:0] update_sel; // Protection update selection.
   wire key_valid; // Supplied key is usable.
   wire feature_enabled; // Stored key has been programmed.
   wire key_match; // Supplied key equals stored key.
   wire index_ok; // Launch index is one, two or three.
   wire wr_status; // Write to command status register.
   wire launch_req; // Software cleared the complete flag.
   wire launch; // Launch that is actually accepted.
   wire acc_clear; // Software clears the access error.
   wire sf_clear; // Software clears the single fault flag.
   wire [7:0] status_byte; // Command status register view.

   assign param_word_0 = param_word[0];
   assign param_word_1 = param_word[1];
   assign param_word_2 = param_word[2];
   assign param_word_3 = param_word[3];

   // ****************************************************************
   // Command decode.
   // ****************************************************************
   // The word layout is set by software before launch.
   assign update_sel = param_word_0[1:0];
   assign key_valid = (param_word_1 != `FPO_KEY_ERASED);
   // An erased stored key can never match, so a launch can only restore or fail.
   assign feature_enabled = (stored_key_i != `FPO_KEY_ERASED);
   assign key_match = key_valid & feature_enabled &
                      (param_word_1 == stored_key_i);
   assign index_ok = (launch_index == `FPO_IDX_W1) |
                     (launch_index == `FPO_IDX_W2) |
                     (launch_index == `FPO_IDX_W3);

   // The override never reports through these flags.
   assign protection_violation = 8'h00;

   // ****************************************************************
   // Register port decode.
   // ****************************************************************
   assign wr_status = wr_i & (addr_i == `FPO_ADDR_CMD_STATUS);
   // A launch is refused while busy or while an old error is pending.
   assign launch_req = wr_status & wdata_i[`FPO_CC_BIT];
   assign launch = launch_req & command_complete_o &
                   ~access_error;
   assign acc_clear = wr_status & wdata_i[`FPO_ACC_BIT];
   assign sf_clear = wr_i & (addr_i == `FPO_ADDR_ERR_STATUS) &
                     wdata_i[`FPO_SFF_BIT];

   // ****************************************************************
   // Command verdict.
   // ****************************************************************
   // Evaluated in the execute state from the captured launch index.
   always @* begin
      cmd_error = 1'b0;
      do_override = 1'b0;
      do_restore = 1'b0;
      if (state == ST_EXEC) begin
         if (param_word_0[`FPO_CODE_HI:`FPO_CODE_LO] !=
             `FPO_CMD_OVERRIDE) begin
            // Other commands are not served here.
            cmd_error = 1'b1;
         end
         if (!index_ok) begin
            cmd_error = 1'b1;
         end
         if (!cmd_allowed_i) begin
            cmd_error = 1'b1;
         end
         if ((update_sel == `FPO_SEL_NONE) &&
             ((launch_index == `FPO_IDX_W2) ||
              (launch_index == `FPO_IDX_W3))) begin
            cmd_error = 1'b1;
         end
         if ((update_sel == `FPO_SEL_NONE) &&
             (launch_index == `FPO_IDX_W1) && key_valid) begin
            cmd_error = 1'b1;
         end
         if (!key_match && !override_active_o) begin
            // Nothing valid is saved, so a restore is impossible.
            cmd_error = 1'b1;
         end
         // An error blocks every command change to the protection registers.
         if (!cmd_error) begin
            do_override = key_match;
            do_restore = ~key_match;
         end
      end
   end

   // ****************************************************************
   // Sequencer next state.
   // ****************************************************************
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (launch) begin
               next_state = ST_EXEC;
            end
         end
         ST_EXEC: begin
            next_state = ST_DONE;
         end
         ST_DONE: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // ****************************************************************
   // Sequencer, complete flag and override status.
   // ****************************************************************
   // The complete flag drops at the launch and rises when the command
   // retires, so software polls it to learn the result is ready.
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= ST_IDLE;
         command_complete_o <= 1'b1;
         override_active_o <= 1'b0;
         launch_index <= 3'h0;
      end else begin
         state <= next_state;
         if (launch) begin
            command_complete_o <= 1'b0;
            launch_index <= param_index;
         end else if (state == ST_DONE) begin
            command_complete_o <= 1'b1;
         end
         if (do_override) begin
            override_active_o <= 1'b1;
         end else if (do_restore) begin
            override_active_o <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Sticky error flags.
   // ****************************************************************
   // A set in the same cycle as a software clear wins, so no event is
   // lost to a badly timed clear.
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         access_error <= 1'b0;
         single_fault_flag <= 1'b0;
      end else begin
         if (cmd_error) begin
            access_error <= 1'b1;
         end else if (acc_clear) begin
            access_error <= 1'b0;
         end
         if (single_fault_i) begin
            single_fault_flag <= 1'b1;
         end else if (sf_clear) begin
            single_fault_flag <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Configuration registers and parameter words.
   // ****************************************************************
   // Parameter words are written through one window picked by the
   // index; writes are held off while a command runs so the captured
   // arguments cannot shift underneath the evaluation.
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         command_complete_irq_en <= 1'b0;
         single_fault_irq_en <= 1'b0;
         param_index <= 3'h0;
         param_word[0] <= `FPO_DATA_ZERO;
         param_word[1] <= `FPO_DATA_ZERO;
         param_word[2] <= `FPO_DATA_ZERO;
         param_word[3] <= `FPO_DATA_ZERO;
      end else if (wr_i) begin
         case (addr_i)
            `FPO_ADDR_CMD_CONFIG: begin
               command_complete_irq_en <= wdata_i[`FPO_CIE_BIT];
               param_index <= wdata_i[`FPO_IDX_HI:`FPO_IDX_LO];
            end
            `FPO_ADDR_ERR_CONFIG: begin
               single_fault_irq_en <= wdata_i[`FPO_SFIE_BIT];
            end
            `FPO_ADDR_PARAM: begin
               // Words above three have no storage and are dropped.
               if (command_complete_o && (param_index[2] == 1'b0)) begin
                  param_word[param_index[1:0]] <= wdata_i;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ****************************************************************
   // Protection registers.
   // ****************************************************************
   fpo_prot_reg #(
      .RESET_VALUE(`FPO_PROT_RESET)
   ) u_pflash (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .sw_we_i(wr_i & (addr_i == `FPO_ADDR_PFLASH_PROT)),
      .sw_data_i(wdata_i[`FPO_PROT_HI:`FPO_PROT_LO]),
      .save_i(do_override),
      .load_i(do_override & update_sel[`FPO_SEL_PF]),
      .load_data_i(param_word_2[`FPO_PROT_HI:`FPO_PROT_LO]),
      .restore_i(do_restore),
      .value_o(pflash_protection_o)
   );

   fpo_prot_reg #(
      .RESET_VALUE(`FPO_PROT_RESET)
   ) u_eeprom (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .sw_we_i(wr_i & (addr_i == `FPO_ADDR_EEPROM_PROT)),
      .sw_data_i(wdata_i[`FPO_PROT_HI:`FPO_PROT_LO]),
      .save_i(do_override),
      .load_i(do_override & update_sel[`FPO_SEL_EE]),
      .load_data_i(param_word_3[`FPO_PROT_HI:`FPO_PROT_LO]),
      .restore_i(do_restore),
      .value_o(eeprom_protection_o)
   );

   // ****************************************************************
   // Interrupt requests.
   // ****************************************************************
   fpo_irq u_cmd_irq (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .flag_i(command_complete_o),
      .enable_i(command_complete_irq_en),
      .irq_o(cmd_irq_o)
   );

   fpo_irq u_err_irq (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .flag_i(single_fault_flag),
      .enable_i(single_fault_irq_en),
      .irq_o(err_irq_o)
   );

   // ****************************************************************
   // Read data.
   // ****************************************************************
   // Verify error and violation bits are wired to the held-low flags.
   assign status_byte = {command_complete_o, 1'b0, access_error,
                         protection_violation[`FPO_PV_BIT], 2'h0,
                         protection_violation[`FPO_VE_HI_BIT],
                         protection_violation[`FPO_VE_LO_BIT]};

   // Read data stand for one cycle after the strobe; an unmapped
   // address reads as zero.
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_o <= `FPO_DATA_ZERO;
      end else if (rd_i) begin
         case (addr_i)
            `FPO_ADDR_CMD_STATUS: begin
               rdata_o <= {8'h00, status_byte};
            end
            `FPO_ADDR_CMD_CONFIG: begin
               rdata_o <= {8'h00, command_complete_irq_en, 4'h0,
                           param_index};
            end
            `FPO_ADDR_ERR_CONFIG: begin
               rdata_o <= {15'h0000, single_fault_irq_en};
            end
            `FPO_ADDR_ERR_STATUS: begin
               rdata_o <= {15'h0000, single_fault_flag};
            end
            `FPO_ADDR_PROT_STATUS: begin
               rdata_o <= {15'h0000, override_active_o};
            end
            `FPO_ADDR_PFLASH_PROT: begin
               rdata_o <= {8'h00, pflash_protection_o};
            end
            `FPO_ADDR_EEPROM_PROT: begin
               rdata_o <= {8'h00, eeprom_protection_o};
            end
            `FPO_ADDR_PARAM: begin
               if (param_index[2] == 1'b0) begin
                  rdata_o <= param_word[param_index[1:0]];
               end else begin
                  rdata_o <= `FPO_DATA_ZERO;
               end
            end
            default: begin
               rdata_o <= `FPO_DATA_ZERO;
            end
         endcase
      end else begin
         rdata_o <= `FPO_DATA_ZERO;
      end
   end

endmodule

// [tb/fpo_top_assertions.sv]
// Port-level assertions for the protection override block.
`timescale 1ns/100ps
`include "fpo_defines.vh"
module fpo_checker (
   // Clock and reset.
   input wire mclk_i,
   input wire arst_n_i,
   // Register port.
   input wire [`FPO_ADDR_W-1:0] addr_i,
   input wire [`FPO_DATA_W-1:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [`FPO_DATA_W-1:0] rdata_o,
   // Flash side.
   input wire [`FPO_DATA_W-1:0] stored_key_i,
   input wire cmd_allowed_i,
   input wire single_fault_i,
   // Outputs under watch.
   input wire [7:0] pflash_protection_o,
   input wire [7:0] eeprom_protection_o,
   input wire command_complete_o,
   input wire override_active_o,
   input wire cmd_irq_o,
   input wire err_irq_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);
   // A command keeps the flag low for two samples, then sets it.
   sequence s_busy;
      !command_complete_o ##1 command_complete_o;
   endsequence
   // The launch write seen one edge earlier.
   sequence s_launch;
      $past(wr_i && addr_i == `FPO_ADDR_CMD_STATUS && wdata_i[7]);
   endsequence
   a_busy_two_cycles: assert property ($fell(command_complete_o) |=> s_busy)
      else $error("complete flag timing wrong");
   a_fall_needs_launch: assert property ($fell(command_complete_o) |-> s_launch)
      else $error("complete flag fell without launch");
   // Protections move only by a command or a direct write.
   a_pf_guarded: assert property ($changed(pflash_protection_o) |->
      $past(!command_complete_o) || $past(wr_i && addr_i == 4'h5))
      else $error("pflash protection changed unexpectedly");
   a_ee_guarded: assert property ($changed(eeprom_protection_o) |->
      $past(!command_complete_o) || $past(wr_i && addr_i == 4'h6))
      else $error("eeprom protection changed unexpectedly");
   a_ovr_in_cmd: assert property ($changed(override_active_o) |->
      $past(!command_complete_o))
      else $error("override bit changed outside a command");
   a_cmd_irq_idle: assert property (cmd_irq_o |-> $past(command_complete_o))
      else $error("command irq while busy");
   a_err_irq_cause: assert property ($rose(err_irq_o) |->
      $past(single_fault_i, 2) || $past(wr_i, 2))
      else $error("error irq rose without cause");
   a_status_clean: assert property ($past(rd_i && addr_i == 4'h0) |->
      rdata_o[4] == 1'b0 && rdata_o[1:0] == 2'b00)
      else $error("violation or verify bit set");
   a_ovr_readback: assert property ($past(rd_i && addr_i == 4'h4) |->
      rdata_o[0] == $past(override_active_o))
      else $error("override status read wrong");
endmodule

bind fpo_top fpo_checker i_chk (
   .mclk_i(mclk_i),
   .arst_n_i(arst_n_i),
   .addr_i(addr_i),
   .wdata_i(wdata_i),
   .wr_i(wr_i),
   .rd_i(rd_i),
   .rdata_o(rdata_o),
   .stored_key_i(stored_key_i),
   .cmd_allowed_i(cmd_allowed_i),
   .single_fault_i(single_fault_i),
   .pflash_protection_o(pflash_protection_o),
   .eeprom_protection_o(eeprom_protection_o),
   .command_complete_o(command_complete_o),
   .override_active_o(override_active_o),
   .cmd_irq_o(cmd_irq_o),
   .err_irq_o(err_irq_o)
);

// [tb/fpo_tb_top.sv]
// Self-checking testbench for the protection override block.
`timescale 1ns/100ps
`include "fpo_defines.vh"
module fpo_tb_top;
   // Design inputs, all given a value at time zero.
   reg mclk_i = 1'b0;
   reg arst_n_i = 1'b0;
   reg [3:0] addr_i = 4'h0;
   reg [15:0] wdata_i = 16'h0000;
   reg wr_i = 1'b0;
   reg rd_i = 1'b0;
   reg [15:0] stored_key_i = 16'h5a3c;
   reg cmd_allowed_i = 1'b1;
   reg single_fault_i = 1'b0;
   // Design outputs.
   wire [15:0] rdata_o;
   wire [7:0] pf_o;
   wire [7:0] ee_o;
   wire cc_o;
   wire ov_o;
   wire ci_o;
   wire ei_o;
   // Reference state: live and saved protections, override bit.
   reg [7:0] m_pf = 8'h00;
   reg [7:0] m_ee = 8'h00;
   reg [7:0] s_pf = 8'h00;
   reg [7:0] s_ee = 8'h00;
   reg m_ov = 1'b0;
   reg irq_en = 1'b0;
   reg [15:0] rk;
   reg [15:0] w [0:3];
   integer errors = 0;
   integer checks_done = 0;
   integer i;
   integer j;
   integer r;

   fpo_top i_dut (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .addr_i(addr_i),
      .wdata_i(wdata_i),
      .wr_i(wr_i),
      .rd_i(rd_i),
      .rdata_o(rdata_o),
      .stored_key_i(stored_key_i),
      .cmd_allowed_i(cmd_allowed_i),
      .single_fault_i(single_fault_i),
      .pflash_protection_o(pf_o),
      .eeprom_protection_o(ee_o),
      .command_complete_o(cc_o),
      .override_active_o(ov_o),
      .cmd_irq_o(ci_o),
      .err_irq_o(ei_o)
   );

   // 200 MHz clock.
   always #2.5 mclk_i = ~mclk_i;

   // ****************************************************************
   // Bus tasks and comparison.
   // ****************************************************************
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
               seen, exp);
         end
      end
   endtask

   task end_sim;
      begin
         $display("Checks %0d, mismatches %0d", checks_done, errors);
         if (errors == 0 && checks_done > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask

   // One-cycle write strobe, entered right after a rising edge.
   task wr(input [3:0] a, input [15:0] d);
      begin
         addr_i <= a;
         wdata_i <= d;
         wr_i <= 1'b1;
         @(posedge mclk_i);
         wr_i <= 1'b0;
         // Idle edge, so a following call never drives the strobe twice.
         @(posedge mclk_i);
      end
   endtask

   // Read data stand only in the cycle after the strobe.
   task rd(input [3:0] a, input [15:0] exp);
      begin
         addr_i <= a;
         rd_i <= 1'b1;
         @(posedge mclk_i);
         rd_i <= 1'b0;
         #1 chk(rdata_o, exp);
         @(posedge mclk_i);
      end
   endtask

   // Loads all four words, predicts the outcome, launches and checks.
   task cmd(input [1:0] sel, input [15:0] key, input [2:0] idx);
      reg bad;
      reg hit;
      integer k;
      begin
         r = $urandom;
         w[0] = {`FPO_CMD_OVERRIDE, 6'h00, sel};
         w[1] = key;
         w[2] = {8'h00, r[7:0]};
         w[3] = {8'h00, r[15:8]};
         for (k = 0; k < 4; k = k + 1) begin
            wr(`FPO_ADDR_CMD_CONFIG, {8'h00, irq_en, 4'h0, k[2:0]});
            wr(`FPO_ADDR_PARAM, w[k]);
         end
         wr(`FPO_ADDR_CMD_CONFIG, {8'h00, irq_en, 4'h0, idx});
         // A stale access error would make the launch be refused.
         wr(`FPO_ADDR_CMD_STATUS, 16'h0020);
         bad = !cmd_allowed_i || idx == 3'h0 || idx > 3'h3 ||
            (sel == 2'h0 && (idx != 3'h1 || key != 16'hffff));
         hit = key == stored_key_i && key != 16'hffff;
         if (!bad && hit) begin
            s_pf = m_pf;
            s_ee = m_ee;
            if (sel[0]) m_pf = r[7:0];
            if (sel[1]) m_ee = r[15:8];
            m_ov = 1'b1;
         end else if (!bad && m_ov) begin
            m_pf = s_pf;
            m_ee = s_ee;
            m_ov = 1'b0;
         end else begin
            bad = 1'b1;
         end
         wr(`FPO_ADDR_CMD_STATUS, 16'h0080);
         #1 chk({15'h0000, cc_o}, 16'h0000);
         for (i = 0; i < 20 && cc_o !== 1'b1; i = i + 1) begin
            @(posedge mclk_i);
            #1;
         end
         if (cc_o !== 1'b1) begin
            errors = errors + 1;
            end_sim;
         end
         @(posedge mclk_i);
         #1 chk({15'h0000, ci_o}, {15'h0000, irq_en});
         chk({pf_o, ee_o}, {m_pf, m_ee});
         chk({15'h0000, ov_o}, {15'h0000, m_ov});
         @(posedge mclk_i);
         rd(`FPO_ADDR_CMD_STATUS, {8'h00, 2'b10, bad, 5'h00});
      end
   endtask

   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial begin
      j = $urandom(32'h8c8219fb);
      repeat (6) @(posedge mclk_i);
      arst_n_i <= 1'b1;
      @(posedge mclk_i);
      #1 chk({13'h0000, cc_o, ov_o, ci_o}, 16'h0004);
      chk({pf_o, ee_o}, 16'h0000);
      @(posedge mclk_i);
      wr(`FPO_ADDR_PFLASH_PROT, 16'h00a5);
      wr(`FPO_ADDR_EEPROM_PROT, 16'h003c);
      m_pf = 8'ha5;
      m_ee = 8'h3c;
      rd(`FPO_ADDR_PFLASH_PROT, 16'h00a5);
      rd(4'hf, 16'h0000);
      $display("test registers done");
      cmd(2'h1, 16'h1234, 3'h3);
      irq_en = 1'b1;
      cmd(2'h3, stored_key_i, 3'h3);
      wr(`FPO_ADDR_PFLASH_PROT, 16'h00ff);
      m_pf = 8'hff;
      rd(`FPO_ADDR_PROT_STATUS, 16'h0001);
      cmd(2'h0, 16'hffff, 3'h1);
      cmd(2'h1, stored_key_i, 3'h3);
      cmd(2'h2, stored_key_i, 3'h2);
      cmd(2'h3, 16'h1234, 3'h3);
      cmd(2'h0, stored_key_i, 3'h2);
      cmd(2'h0, stored_key_i, 3'h1);
      cmd(2'h3, stored_key_i, 3'h0);
      cmd(2'h3, stored_key_i, 3'h4);
      cmd_allowed_i <= 1'b0;
      cmd(2'h3, stored_key_i, 3'h3);
      cmd_allowed_i <= 1'b1;
      cmd(2'h3, stored_key_i, 3'h3);
      stored_key_i <= 16'hffff;
      cmd(2'h3, 16'hffff, 3'h3);
      stored_key_i <= 16'h5a3c;
      $display("test directed done");
      // Random mix of keys, selections, indices and direct writes.
      for (j = 0; j < 40; j = j + 1) begin
         r = $urandom;
         cmd_allowed_i <= r[2:0] != 3'h0;
         irq_en = r[3];
         rk = r[4] ? stored_key_i : (r[5] ? 16'hffff : r[31:16]);
         if (r[11]) begin
            wr(`FPO_ADDR_EEPROM_PROT, {8'h00, r[23:16]});
            m_ee = r[23:16];
         end
         cmd(r[7:6], rk, r[10:8]);
      end
      $display("test random done");
      single_fault_i <= 1'b1;
      @(posedge mclk_i);
      single_fault_i <= 1'b0;
      wr(`FPO_ADDR_ERR_CONFIG, 16'h0001);
      rd(`FPO_ADDR_ERR_STATUS, 16'h0001);
      #1 chk({15'h0000, ei_o}, 16'h0001);
      @(posedge mclk_i);
      wr(`FPO_ADDR_ERR_STATUS, 16'h0001);
      @(posedge mclk_i);
      #1 chk({15'h0000, ei_o}, 16'h0000);
      $display("test fault irq done");
      end_sim;
   end
endmodule
